/* File: dv/frpst_flash_model.sv */
// Behavioural model of the parallel flash on the far side of the host
`timescale 1ns/10ps
module frpst_flash_model #(
    parameter int unsigned ALGO_CYC  = frpst_pkg::READY_ALGO_CYC,
    parameter int unsigned STBY_CYC  = frpst_pkg::STANDBY_CYC,
    parameter int unsigned SLOW_CYC  = 1000,
    parameter logic [2:0]  SUSP_SECT = 3'h7
) (
    input  wire logic        clk_in,
    input  wire logic [17:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        reset_n_in,
    input  wire logic        unprot_hv_in,
    input  wire logic        byte_n_in,
    input  wire logic        slow_in,
    output logic [15:0]      dq_out,
    output logic             ready_busy_n_out,
    output logic             standby_out,
    output logic             prot_sel_out,
    output int               viol_cnt_out
);
    localparam int WORD_CYC = 11000 / frpst_pkg::CYC_NS;
    logic [15:0] mem [int];
    logic [15:0] last_q   = 16'h0000;
    logic [15:0] wd       = 16'h0000;
    logic [17:0] wa       = 18'h00000;
    logic        rst_p    = 1'b1;
    logic        we_p     = 1'b1;
    logic        whv      = 1'b0;
    logic        acc_p    = 1'b0;
    logic        rst_algo = 1'b0;
    logic        tog6     = 1'b0;
    logic        tog2     = 1'b0;
    logic        acc;
    int          cyc      = 0;
    int          rst_fall = -100000;
    int          rst_rise = -100000;
    int          algo     = 0;
    int          bdly     = 0;
    int          hv_cyc   = 0;
    // ------------------------------------------------------------
    // Pin sampling, algorithm timing and status bits
    // ------------------------------------------------------------
    initial begin
        viol_cnt_out = 0;
        prot_sel_out = 1'b0;
        standby_out = 1'b0;
    end
    always @(negedge clk_in) begin
        cyc++;
        hv_cyc = unprot_hv_in ? hv_cyc + 1 : 0;
        if (algo > 0) algo--;
        if (bdly > 0) bdly--;
        if (reset_n_in === 1'b0 && rst_p) begin
            rst_fall = cyc;
            rst_algo = (algo > 0);
            algo = 0;
        end
        if (reset_n_in === 1'b1 && !rst_p) rst_rise = cyc;
        rst_p = (reset_n_in !== 1'b0);
        standby_out = !rst_p && (cyc - rst_fall >= STBY_CYC);
        acc = (ce_n_in === 1'b0) && (!oe_n_in || !we_n_in);
        if (acc && !acc_p) begin
            if (!rst_p || cyc - rst_fall <
                (rst_algo ? ALGO_CYC : frpst_pkg::READY_IDLE_CYC))
                viol_cnt_out++;
            if (!oe_n_in && cyc - rst_rise < frpst_pkg::RESET_HIGH_CYC)
                viol_cnt_out++;
            if (!we_n_in && unprot_hv_in &&
                hv_cyc < frpst_pkg::UNPROT_SETUP_CYC)
                viol_cnt_out++;
            if (!oe_n_in && algo > 0) begin
                tog6 = ~tog6;
                if (addr_in[17:15] == SUSP_SECT) tog2 = ~tog2;
            end
        end
        acc_p = acc;
        if (!we_n_in && !ce_n_in) begin
            wa = addr_in;
            wd = dq_in;
            // Elevated level is judged while the write pulse is low
            whv = unprot_hv_in;
        end
        if (we_n_in === 1'b1 && !we_p) begin
            if (whv) begin
                if (wa[1] !== 1'b1 || wa[0] !== 1'b0) viol_cnt_out++;
                prot_sel_out = wa[6];
            end else begin
                if (algo > 0) viol_cnt_out++;
                mem[int'(wa)] = wd;
                algo = slow_in ? SLOW_CYC : byte_n_in ? WORD_CYC :
                    frpst_pkg::PROGRAM_TYP_CYC;
                bdly = frpst_pkg::BUSY_VALID_CYC;
            end
        end
        we_p = (we_n_in !== 1'b0);
        // Shows ready until the busy flag is valid, fooling a hasty host
        ready_busy_n_out = !(algo > 0 && bdly == 0);
        if (ce_n_in === 1'b0 && oe_n_in === 1'b0) begin
            last_q = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] :
                addr_in[15:0] ^ 16'h5a5a;
            if (algo > 0) begin
                last_q[7] = ~wd[7];
                last_q[6] = tog6;
                last_q[2] = tog2;
            end
            dq_out = last_q;
        end else
            dq_out = ~last_q;
    end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the flash sequencer host
`timescale 1ns/10ps
module tb;
    localparam int W = 40;
    logic        clk_in, rst_in, req_in, reset_req_in, standby_in;
    logic        byte_mode_in, slow, busy_out, done_out, timeout_out;
    logic        dq_oe, ce_n, oe_n, we_n, rst_n, hv, byte_n, rb_n;
    logic        stby, psel;
    logic [1:0]  op_in;
    logic [17:0] addr_in, fa;
    logic [15:0] wdata_in, rdata_out, host_dq, mdl_dq, dq_bus;
    int          viol, errors, cmp_count, lo_run, last_lo, n;
    assign dq_bus = dq_oe ? host_dq : mdl_dq;
    frpst_host #(.TIMEOUT(400), .ALGO_WAIT(W), .STBY_WAIT(W)) u_frpst_host (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .op_in(op_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .reset_req_in(reset_req_in),
        .standby_in(standby_in), .byte_mode_in(byte_mode_in),
        .flash_dq_in(dq_bus), .ready_busy_n_in(rb_n), .busy_out(busy_out),
        .done_out(done_out), .timeout_out(timeout_out),
        .rdata_out(rdata_out), .flash_addr_out(fa), .flash_dq_out(host_dq),
        .flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n),
        .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .flash_reset_n_out(rst_n), .flash_unprot_hv_out(hv),
        .flash_byte_n_out(byte_n));
    frpst_flash_model #(.ALGO_CYC(W), .STBY_CYC(W)) u_frpst_flash_model (
        .clk_in(clk_in), .addr_in(fa), .dq_in(dq_bus), .ce_n_in(ce_n),
        .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(rst_n),
        .unprot_hv_in(hv), .byte_n_in(byte_n), .slow_in(slow),
        .dq_out(mdl_dq), .ready_busy_n_out(rb_n), .standby_out(stby),
        .prot_sel_out(psel), .viol_cnt_out(viol));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        if (rst_n === 1'b0)
            lo_run++;
        else if (lo_run > 0) begin
            last_lo = lo_run;
            lo_run = 0;
        end
    end
    // ------------------------------------------------------------
    // Compare, drive and verdict tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic chk_min(input int lo, input int got);
        cmp_count++;
        if (got < lo) begin
            errors++;
            $display("MISMATCH t=%0t min=%h got=%h", $time, lo, got);
        end
    endtask
    task automatic wait_done();
        n = 0;
        while (done_out !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        chk_val(1, done_out);
    endtask
    task automatic do_op(input logic [1:0] op, input logic [17:0] a,
                         input logic [15:0] d);
        @(negedge clk_in);
        op_in = op;
        addr_in = a;
        wdata_in = d;
        req_in = 1'b1;
        @(negedge clk_in);
        req_in = 1'b0;
        wait_done();
    endtask
    task automatic hw_reset();
        @(negedge clk_in);
        reset_req_in = 1'b1;
        @(negedge clk_in);
        reset_req_in = 1'b0;
        wait_done();
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_idle();
        hw_reset();
        chk_min(frpst_pkg::RESET_PULSE_CYC, last_lo);
        chk_val(1, rst_n);
    endtask
    task automatic t_write_read();
        logic [17:0] a [2] = '{18'h00000, 18'h3ffff};
        logic [15:0] d [2] = '{16'ha5c3, 16'h0ff0};
        for (int i = 0; i < 2; i++) begin
            byte_mode_in = i[0];
            do_op(frpst_pkg::OP_WRITE, a[i], d[i]);
            chk_val(0, timeout_out);
            chk_val(!i[0], byte_n);
            do_op(frpst_pkg::OP_READ, a[i], 16'h0000);
            chk_val(d[i], rdata_out);
        end
        byte_mode_in = 1'b0;
    endtask
    task automatic t_protect();
        do_op(frpst_pkg::OP_PROTECT, 18'h00000, 16'h0000);
        chk_val(0, psel);
        do_op(frpst_pkg::OP_UNPROTECT, 18'h00000, 16'h0000);
        chk_val(1, psel);
        chk_val(0, viol);
    endtask
    task automatic t_timeout_reset();
        slow = 1'b1;
        do_op(frpst_pkg::OP_WRITE, 18'h00100, 16'h1234);
        chk_val(1, timeout_out);
        hw_reset();
        chk_min(W, last_lo);
        slow = 1'b0;
        do_op(frpst_pkg::OP_READ, 18'h0002a, 16'h0000);
        chk_val(16'h002a ^ 16'h5a5a, rdata_out);
        chk_val(0, timeout_out);
    endtask
    task automatic t_standby();
        @(negedge clk_in);
        standby_in = 1'b1;
        repeat (W + 5) @(negedge clk_in);
        chk_val(1, stby);
        chk_val(0, rst_n);
        standby_in = 1'b0;
        n = 0;
        while (busy_out !== 1'b0 && n < 200) begin
            @(negedge clk_in);
            n++;
        end
        do_op(frpst_pkg::OP_READ, 18'h00100, 16'h0000);
        chk_val(16'h1234, rdata_out);
    endtask
    initial begin
        errors = 0;
        cmp_count = 0;
        lo_run = 0;
        last_lo = 0;
        rst_in = 1'b1;
        req_in = 1'b0;
        op_in = 2'h0;
        addr_in = 18'h00000;
        wdata_in = 16'h0000;
        reset_req_in = 1'b0;
        standby_in = 1'b0;
        byte_mode_in = 1'b0;
        slow = 1'b0;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        chk_val(5'h1e, {ce_n, oe_n, we_n, rst_n, busy_out});
        t_reset_idle();
        t_write_read();
        t_protect();
        t_timeout_reset();
        t_standby();
        chk_val(0, viol);
        give_verdict();
    end
    initial begin
        #(40 * 20000);
        errors++;
        give_verdict();
    end
endmodule

/* File: logic/frpst_host.sv */
// Host controller sequencing reset, writes, reads and status polling
`timescale 1ns/10ps
// Notes on behaviour
// - Reset during algorithm: wait 20 us
// - Reset while idle: wait 500 ns
// - Reset high 50 ns before read
// - Standby needs reset low 20 us
// - Sample ready/busy 90 ns after write
// - Toggle bits flip on successive reads
// - Protect: addr1 high, addr0 low, sel
// - Elevated reset 4 us before write
module frpst_host #(
    parameter int unsigned AW      = 18,
    parameter int unsigned DW      = 16,
    parameter int unsigned TIMEOUT = 9000,
    parameter int unsigned ALGO_WAIT = frpst_pkg::READY_ALGO_CYC,
    parameter int unsigned STBY_WAIT = frpst_pkg::STANDBY_CYC
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          req_in,
    input  wire logic [1:0]    op_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic          reset_req_in,
    input  wire logic          standby_in,
    input  wire logic          byte_mode_in,
    input  wire logic [DW-1:0] flash_dq_in,
    input  wire logic          ready_busy_n_in,
    output logic               busy_out,
    output logic               done_out,
    output logic               timeout_out,
    output logic [DW-1:0]      rdata_out,
    output logic [AW-1:0]      flash_addr_out,
    output logic [DW-1:0]      flash_dq_out,
    output logic               flash_dq_oe_out,
    output logic               flash_ce_n_out,
    output logic               flash_oe_n_out,
    output logic               flash_we_n_out,
    output logic               flash_reset_n_out,
    output logic               flash_unprot_hv_out,
    output logic               flash_byte_n_out
);
    localparam int unsigned CW = 20;
    localparam logic [CW-1:0] ALGO_C = CW'(ALGO_WAIT);
    localparam logic [CW-1:0] STBY_C = CW'(STBY_WAIT);
    localparam logic [CW-1:0] TMO_C  = CW'(TIMEOUT);

    frpst_pkg::frpst_state_t st_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] tmo_r;
    logic [1:0]    op_r;
    logic          algo_r;
    logic          was_stby_r;
    logic [DW-1:0] dq_s1_r, dq_s2_r, prev_r;
    logic          rb_s1_r, rb_s2_r;
    logic          toggled;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        dq_s1_r <= flash_dq_in;
        dq_s2_r <= dq_s1_r;
        rb_s1_r <= ready_busy_n_in;
        rb_s2_r <= rb_s1_r;
    end

    // Primary bit compared without a valid sector address
    assign toggled = dq_s2_r[frpst_pkg::PRIMARY_TOGGLE_POS] !=
                     prev_r[frpst_pkg::PRIMARY_TOGGLE_POS];

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r                <= frpst_pkg::FRPST_IDLE;
            cnt_r               <= '0;
            tmo_r               <= '0;
            op_r                <= frpst_pkg::OP_READ;
            algo_r              <= 1'b0;
            was_stby_r          <= 1'b0;
            prev_r              <= '0;
            busy_out            <= 1'b0;
            done_out            <= 1'b0;
            timeout_out         <= 1'b0;
            rdata_out           <= '0;
            flash_addr_out      <= '0;
            flash_dq_out        <= '0;
            flash_dq_oe_out     <= 1'b0;
            flash_ce_n_out      <= 1'b1;
            flash_oe_n_out      <= 1'b1;
            flash_we_n_out      <= 1'b1;
            flash_reset_n_out   <= 1'b1;
            flash_unprot_hv_out <= 1'b0;
            flash_byte_n_out    <= 1'b1;
        end else begin
            done_out <= 1'b0;
            case (st_r)
                frpst_pkg::FRPST_IDLE: begin
                    busy_out <= 1'b0;
                    flash_ce_n_out <= 1'b1;
                    flash_oe_n_out <= 1'b1;
                    flash_we_n_out <= 1'b1;
                    flash_dq_oe_out <= 1'b0;
                    cnt_r <= '0;
                    if (reset_req_in || standby_in) begin
                        was_stby_r <= standby_in;
                        flash_reset_n_out <= 1'b0;
                        busy_out <= 1'b1;
                        st_r <= frpst_pkg::FRPST_RSTLO;
                    end else if (req_in) begin
                        busy_out <= 1'b1;
                        timeout_out <= 1'b0;
                        op_r <= op_in;
                        flash_byte_n_out <= ~byte_mode_in;
                        flash_addr_out <= addr_in;
                        if (op_in == frpst_pkg::OP_PROTECT ||
                            op_in == frpst_pkg::OP_UNPROTECT) begin
                            flash_addr_out[frpst_pkg::PROT_ONE_POS] <= 1'b1;
                            flash_addr_out[frpst_pkg::PROT_ZERO_POS] <= 1'b0;
                            flash_addr_out[frpst_pkg::PROT_SEL_POS] <=
                                (op_in == frpst_pkg::OP_UNPROTECT);
                        end
                        flash_dq_out <= wdata_in;
                        flash_ce_n_out <= 1'b0;
                        if (op_in == frpst_pkg::OP_READ) begin
                            flash_oe_n_out <= 1'b0;
                            st_r <= frpst_pkg::FRPST_PULSE;
                        end else if (op_in == frpst_pkg::OP_WRITE) begin
                            flash_dq_oe_out <= 1'b1;
                            flash_we_n_out <= 1'b0;
                            st_r <= frpst_pkg::FRPST_PULSE;
                        end else begin
                            flash_unprot_hv_out <= 1'b1;
                            st_r <= frpst_pkg::FRPST_UNPRT;
                        end
                    end
                end
                frpst_pkg::FRPST_UNPRT: begin
                    // Elevated reset level before the first write
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= CW'(frpst_pkg::UNPROT_SETUP_CYC - 1)) begin
                        cnt_r <= '0;
                        flash_dq_oe_out <= 1'b1;
                        flash_we_n_out <= 1'b0;
                        st_r <= frpst_pkg::FRPST_PULSE;
                    end
                end
                frpst_pkg::FRPST_PULSE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (op_r == frpst_pkg::OP_READ) begin
                        if (cnt_r >= CW'(frpst_pkg::READ_ACC_CYC)) begin
                            rdata_out <= dq_s2_r;
                            flash_oe_n_out <= 1'b1;
                            flash_ce_n_out <= 1'b1;
                            done_out <= 1'b1;
                            st_r <= frpst_pkg::FRPST_IDLE;
                        end
                    end else if (cnt_r >=
                                 CW'(frpst_pkg::WRITE_PULSE_CYC - 1)) begin
                        flash_we_n_out <= 1'b1;
                        flash_ce_n_out <= 1'b1;
                        flash_dq_oe_out <= 1'b0;
                        flash_unprot_hv_out <= 1'b0;
                        cnt_r <= '0;
                        tmo_r <= '0;
                        algo_r <= 1'b1;
                        st_r <= frpst_pkg::FRPST_BUSYW;
                    end
                end
                frpst_pkg::FRPST_BUSYW: begin
                    // Ready/busy ignored until valid
                    cnt_r <= cnt_r + 1'b1;
                    tmo_r <= tmo_r + 1'b1;
                    if (cnt_r >= CW'(frpst_pkg::BUSY_VALID_CYC) + CW'(2)) begin
                        flash_ce_n_out <= 1'b0;
                        flash_oe_n_out <= 1'b0;
                        cnt_r <= '0;
                        st_r <= frpst_pkg::FRPST_POLL1;
                    end
                end
                frpst_pkg::FRPST_POLL1: begin
                    // OE pulsed per status read
                    cnt_r <= cnt_r + 1'b1;
                    tmo_r <= tmo_r + 1'b1;
                    if (cnt_r >= CW'(frpst_pkg::READ_ACC_CYC)) begin
                        prev_r <= dq_s2_r;
                        flash_oe_n_out <= 1'b1;
                        cnt_r <= '0;
                        st_r <= frpst_pkg::FRPST_POLL2;
                    end
                end
                frpst_pkg::FRPST_POLL2: begin
                    // Keep polling until stable or ready
                    cnt_r <= cnt_r + 1'b1;
                    tmo_r <= tmo_r + 1'b1;
                    if (cnt_r == '0) begin
                        flash_oe_n_out <= 1'b0;
                    end else if (cnt_r >= CW'(frpst_pkg::READ_ACC_CYC)) begin
                        flash_oe_n_out <= 1'b1;
                        cnt_r <= '0;
                        prev_r <= dq_s2_r;
                        if (!toggled || rb_s2_r) begin
                            st_r <= frpst_pkg::FRPST_DONE;
                        end else if (tmo_r >= TMO_C) begin
                            // Timeout allows the program duration
                            timeout_out <= 1'b1;
                            st_r <= frpst_pkg::FRPST_DONE;
                        end
                    end
                end
                frpst_pkg::FRPST_DONE: begin
                    flash_ce_n_out <= 1'b1;
                    // A timed-out algorithm may still be running, so a
                    // later reset keeps the long recovery
                    if (!timeout_out) begin
                        algo_r <= 1'b0;
                    end
                    done_out <= 1'b1;
                    st_r <= frpst_pkg::FRPST_IDLE;
                end
                frpst_pkg::FRPST_RSTLO: begin
                    cnt_r <= cnt_r + 1'b1;
                    flash_ce_n_out <= 1'b1;
                    flash_oe_n_out <= 1'b1;
                    flash_we_n_out <= 1'b1;
                    flash_dq_oe_out <= 1'b0;
                    // Low time covers recovery
                    if (was_stby_r ? (standby_in || cnt_r < STBY_C - 1'b1)
                        : cnt_r < (algo_r ? ALGO_C - 1'b1 :
                           CW'(frpst_pkg::RESET_PULSE_CYC +
                               frpst_pkg::READY_IDLE_CYC - 1))) begin
                        st_r <= frpst_pkg::FRPST_RSTLO;
                    end else begin
                        flash_reset_n_out <= 1'b1;
                        algo_r <= 1'b0;
                        cnt_r <= '0;
                        st_r <= frpst_pkg::FRPST_RSTHI;
                    end
                end
                frpst_pkg::FRPST_RSTHI: begin
                    // Reset high before any read
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= CW'(frpst_pkg::RESET_HIGH_CYC - 1)) begin
                        done_out <= 1'b1;
                        st_r <= frpst_pkg::FRPST_IDLE;
                    end
                end
                default: st_r <= frpst_pkg::FRPST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_write_end;
        $rose(flash_we_n_out) && st_r == frpst_pkg::FRPST_BUSYW;
    endsequence
    AST_BUSY_WAIT: assert property (@(posedge clk_in) disable iff (rst_in)
        s_write_end |-> (flash_oe_n_out [*3]))
        else $error("Status read too soon after write");
    AST_RST_HIGH: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(flash_reset_n_out) |-> flash_ce_n_out [*2])
        else $error("Access too soon after reset release");
    AST_RST_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(flash_reset_n_out) |-> !flash_reset_n_out [*8])
        else $error("Reset low time too short");
    AST_PROT_ADDR: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == frpst_pkg::FRPST_UNPRT |->
        flash_addr_out[frpst_pkg::PROT_ONE_POS] &&
        !flash_addr_out[frpst_pkg::PROT_ZERO_POS] &&
        (flash_addr_out[frpst_pkg::PROT_SEL_POS] ==
         (op_r == frpst_pkg::OP_UNPROTECT)))
        else $error("Protect address bits wrong");
    AST_UNPROT_SETUP: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(flash_unprot_hv_out) |-> flash_we_n_out [*8])
        else $error("Write during unprotect setup");
    AST_NO_CMD_POLL: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == frpst_pkg::FRPST_POLL2 |-> flash_we_n_out && !flash_dq_oe_out)
        else $error("Command issued while polling");
    AST_DONE_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == frpst_pkg::FRPST_DONE |=> done_out ##1 !done_out)
        else $error("Done not a single pulse");
    AST_ALGO_RST: assert property (@(posedge clk_in) disable iff (rst_in)
        ($fell(flash_reset_n_out) && algo_r) |-> !flash_reset_n_out [*8])
        else $error("Algorithm reset released too early");
endmodule

/* File: pkg/frpst_pkg.sv */
// Package of timing constants and encodings for the flash sequencer host
package frpst_pkg;
    localparam int unsigned CLK_MHZ          = 25;
    // Times in ns, cycle counts derived (minimums round up)
    localparam int unsigned READY_ALGO_NS    = 20000;
    localparam int unsigned READY_IDLE_NS    = 500;
    localparam int unsigned RESET_PULSE_NS   = 500;
    localparam int unsigned RESET_HIGH_NS    = 50;
    localparam int unsigned STANDBY_NS       = 20000;
    localparam int unsigned BUSY_VALID_NS    = 90;
    localparam int unsigned UNPROT_SETUP_NS  = 4000;
    localparam int unsigned PROGRAM_TYP_NS   = 9000;
    localparam int unsigned WRITE_PULSE_NS   = 50;
    localparam int unsigned READ_ACC_NS      = 120;
    localparam int unsigned CYC_NS           = 1000 / CLK_MHZ;
    localparam int unsigned READY_ALGO_CYC   =
        (READY_ALGO_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned READY_IDLE_CYC   =
        (READY_IDLE_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned RESET_PULSE_CYC  =
        (RESET_PULSE_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned RESET_HIGH_CYC   =
        (RESET_HIGH_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned STANDBY_CYC      =
        (STANDBY_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned BUSY_VALID_CYC   =
        (BUSY_VALID_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned UNPROT_SETUP_CYC =
        (UNPROT_SETUP_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned PROGRAM_TYP_CYC  =
        (PROGRAM_TYP_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned WRITE_PULSE_CYC  =
        (WRITE_PULSE_NS + CYC_NS - 1) / CYC_NS;
    localparam int unsigned READ_ACC_CYC     =
        (READ_ACC_NS + CYC_NS - 1) / CYC_NS;
    // Status bit positions on the data bus
    localparam int unsigned SUSPEND_TOGGLE_POS = 2;
    localparam int unsigned PRIMARY_TOGGLE_POS = 6;
    // Protect address bit positions and levels
    localparam int unsigned PROT_SEL_POS     = 6;
    localparam int unsigned PROT_ONE_POS     = 1;
    localparam int unsigned PROT_ZERO_POS    = 0;
    localparam logic [1:0]  OP_WRITE         = 2'h0;
    localparam logic [1:0]  OP_READ          = 2'h1;
    localparam logic [1:0]  OP_PROTECT       = 2'h2;
    localparam logic [1:0]  OP_UNPROTECT     = 2'h3;
    typedef enum logic [3:0] {
        FRPST_IDLE  = 4'h0,
        FRPST_SETUP = 4'h1,
        FRPST_PULSE = 4'h3,
        FRPST_BUSYW = 4'h2,
        FRPST_POLL1 = 4'h6,
        FRPST_POLL2 = 4'h7,
        FRPST_DONE  = 4'h5,
        FRPST_RSTLO = 4'h4,
        FRPST_RSTHI = 4'hc,
        FRPST_UNPRT = 4'hd
    } frpst_state_t;
endpackage
